//--- hdl/phpic_pkg.sv
// Overview of operation
// RULE_01 - Write latches when store or select rises.
// RULE_02 - Read drives register while fetch, select low.
// RULE_03 - Select high releases bus, ignores strobes.
// RULE_04 - Two address inputs choose the register.
// RULE_05 - Interrupt pin only pulls low, never high.
// RULE_06 - Reset low clears registers and bus state; status loads STATUS_IDLE and indirect loads INDIRECT_RESET.
// RULE_07 - Serial pins open-drain, levels sampled as inputs.
// RULE_08 - Four direct locations: status/pointer, data, indirect, control.
// RULE_09 - Non-idle state sets flag, asserts interrupt.
// RULE_10 - Strobes synchronised; one update per write.
package phpic_pkg;

	localparam int         DATA_W         = 8;
	localparam int         PTR_W          = 3;
	localparam int         CODE_W         = 6;
	localparam int         INDIRECT_DEPTH = 7;
	localparam int         SYNC_W         = 5;

	localparam logic [1:0] ADDR_STATUS    = 2'h0;
	localparam logic [1:0] ADDR_SERIAL    = 2'h1;
	localparam logic [1:0] ADDR_INDIRECT  = 2'h2;
	localparam logic [1:0] ADDR_CONTROL   = 2'h3;

	localparam int         SYNC_SEL       = 4;
	localparam int         SYNC_STORE     = 3;
	localparam int         SYNC_FETCH     = 2;
	localparam int         SYNC_SCL       = 1;
	localparam int         SYNC_SDA       = 0;
	localparam logic [4:0] SYNC_RESET     = 5'h1f;

	localparam int         SI_BIT         = 3;
	localparam int         CODE_LSB       = 2;

	localparam logic [7:0] STATUS_IDLE    = 8'hf8;
	localparam logic [7:0] POINTER_RESET  = 8'h00;
	localparam logic [7:0] SERIAL_RESET   = 8'h00;
	localparam logic [7:0] CONTROL_RESET  = 8'h00;
	localparam logic [2:0] PRESET_INDEX   = 3'h5;

	localparam logic [6:0][7:0] INDIRECT_RESET = {
		8'h00, 8'h00, 8'hff, 8'h86, 8'h9d, 8'he0, 8'h01
	};

endpackage

//--- hdl/phpic_sync.sv
`timescale 1ns/100ps
module phpic_sync
	import phpic_pkg::*;
#(
	parameter int               WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic stage1;
			logic stage2;
			logic next_stage1;
			logic next_stage2;

			always_comb begin
				next_stage1 = i_async[g];
				next_stage2 = stage1;
			end

			// The first stage feeds only the second stage.
			always_ff @(posedge i_clock) begin
				if (!i_rst_n) begin
					stage1 <= RESET_VALUE[g];
					stage2 <= RESET_VALUE[g];
				end else begin
					stage1 <= next_stage1;
					stage2 <= next_stage2;
				end
			end

			assign o_sync[g] = stage2;
		end
	endgenerate

endmodule

//--- hdl/phpic_host_port.sv
`timescale 1ns/100ps
module phpic_host_port
	import phpic_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic              i_rst_n,
	input  wire logic              i_chip_sel_n,
	input  wire logic              i_store_n,
	input  wire logic              i_fetch_n,
	input  wire logic              i_addr_bit_low,
	input  wire logic              i_addr_bit_high,
	input  wire logic [DATA_W-1:0] i_host_bus_bits,
	output logic      [DATA_W-1:0] o_host_bus_bits,
	output logic                   o_host_bus_oe,
	output logic                   o_irq_n_out,
	output logic                   o_irq_n_oe,
	input  wire logic              i_scl_in,
	output logic                   o_scl_out,
	output logic                   o_scl_oe,
	input  wire logic              i_sda_in,
	output logic                   o_sda_out,
	output logic                   o_sda_oe,
	input  wire logic [CODE_W-1:0] i_bus_state_code,
	input  wire logic              i_bus_state_valid,
	input  wire logic [DATA_W-1:0] i_rx_byte,
	input  wire logic              i_rx_byte_valid,
	input  wire logic              i_scl_pull,
	input  wire logic              i_sda_pull,
	output logic                   o_scl_level,
	output logic                   o_sda_level,
	output logic                   o_si,
	output logic      [DATA_W-1:0] o_control_reg,
	output logic      [DATA_W-1:0] o_serial_byte_reg,
	output logic      [PTR_W-1:0]  o_pointer_reg
);

	logic [SYNC_W-1:0] sync_q;
	logic              wr_active;
	logic              rd_active;
	logic              wr_commit;
	logic              wr_pins;

	logic              wr_active_d;
	logic [DATA_W-1:0] hold_data;
	logic [1:0]        hold_addr;
	logic [DATA_W-1:0] status_code_reg;
	logic [PTR_W-1:0]  pointer_reg;
	logic [DATA_W-1:0] serial_byte_reg;
	logic [DATA_W-1:0] control_reg;
	logic [DATA_W-1:0] indirect [INDIRECT_DEPTH];
	logic              si;
	logic [DATA_W-1:0] bus_out;
	logic              bus_oe;
	logic              irq_oe;
	logic              scl_oe;
	logic              sda_oe;
	logic              scl_level;
	logic              sda_level;
	logic              pin_low;

	logic              next_wr_active_d;
	logic [DATA_W-1:0] next_hold_data;
	logic [1:0]        next_hold_addr;
	logic [DATA_W-1:0] next_status_code_reg;
	logic [PTR_W-1:0]  next_pointer_reg;
	logic [DATA_W-1:0] next_serial_byte_reg;
	logic [DATA_W-1:0] next_control_reg;
	logic [DATA_W-1:0] next_indirect [INDIRECT_DEPTH];
	logic              next_si;
	logic [DATA_W-1:0] next_bus_out;
	logic              next_bus_oe;
	logic              next_irq_oe;
	logic              next_scl_oe;
	logic              next_sda_oe;
	logic              next_scl_level;
	logic              next_sda_level;
	logic [DATA_W-1:0] read_value;
	logic              state_entry;
	logic              si_clear;

	// Host strobes and the serial pin levels cross into the clock domain here.
	phpic_sync #(
		.WIDTH       (SYNC_W),
		.RESET_VALUE (SYNC_RESET)
	) u_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({i_chip_sel_n, i_store_n, i_fetch_n, i_scl_in, i_sda_in}),
		.o_sync  (sync_q)
	); // [RULE_10]

	always_comb begin
		wr_active = !sync_q[SYNC_SEL] && !sync_q[SYNC_STORE]; // [RULE_01] [RULE_03]
		rd_active = !sync_q[SYNC_SEL] && !sync_q[SYNC_FETCH]; // [RULE_02] [RULE_03]
		// The pins qualify the data capture, because the synchronised strobes trail the rising edge.
		wr_pins   = !i_chip_sel_n && !i_store_n; // [RULE_01]
		// A single commit pulse on the end of the write, whichever strobe rises first.
		wr_commit = wr_active_d && !wr_active; // [RULE_01] [RULE_10]
	end

	always_comb begin
		read_value = '0;
		case ({i_addr_bit_high, i_addr_bit_low}) // [RULE_04] [RULE_08]
			ADDR_STATUS: begin
				read_value = status_code_reg;
			end
			ADDR_SERIAL: begin
				read_value = serial_byte_reg;
			end
			ADDR_INDIRECT: begin
				if (pointer_reg < PTR_W'(INDIRECT_DEPTH) && pointer_reg != PRESET_INDEX) begin
					read_value = indirect[pointer_reg];
				end
			end
			ADDR_CONTROL: begin
				read_value         = control_reg;
				read_value[SI_BIT] = si;
			end
			default: begin
				read_value = '0;
			end
		endcase
	end

	always_comb begin
		next_wr_active_d     = wr_active;
		next_hold_data       = hold_data;
		next_hold_addr       = hold_addr;
		next_status_code_reg = status_code_reg;
		next_pointer_reg     = pointer_reg;
		next_serial_byte_reg = serial_byte_reg;
		next_control_reg     = control_reg;
		for (int i = 0; i < INDIRECT_DEPTH; i++) begin
			next_indirect[i] = indirect[i];
		end
		si_clear    = 1'b0;
		state_entry = 1'b0;

		// The last data and address seen before a strobe rises are the ones committed later.
		if (wr_pins) begin
			next_hold_data = i_host_bus_bits; // [RULE_01]
			next_hold_addr = {i_addr_bit_high, i_addr_bit_low}; // [RULE_04]
		end

		if (wr_commit) begin
			case (hold_addr) // [RULE_08]
				ADDR_STATUS: begin
					next_pointer_reg = hold_data[PTR_W-1:0];
				end
				ADDR_SERIAL: begin
					next_serial_byte_reg = hold_data;
				end
				ADDR_INDIRECT: begin
					if (pointer_reg < PTR_W'(INDIRECT_DEPTH)) begin
						next_indirect[pointer_reg] = hold_data;
					end
				end
				ADDR_CONTROL: begin
					next_control_reg         = hold_data;
					next_control_reg[SI_BIT] = 1'b0;
					si_clear                 = !hold_data[SI_BIT];
				end
				default: begin
					next_control_reg = control_reg;
				end
			endcase
		end

		if (i_rx_byte_valid) begin
			next_serial_byte_reg = i_rx_byte;
		end

		if (i_bus_state_valid) begin
			next_status_code_reg = {i_bus_state_code, 2'b00};
			state_entry          = next_status_code_reg != STATUS_IDLE; // [RULE_09]
		end

		// A new state entry in the cycle of a clear keeps the flag set.
		next_si = state_entry || (si && !si_clear); // [RULE_09]

		next_bus_oe  = rd_active; // [RULE_02] [RULE_03]
		next_bus_out = rd_active ? read_value : '0; // [RULE_02]
		next_irq_oe  = next_si; // [RULE_05] [RULE_09]

		next_scl_oe    = i_scl_pull; // [RULE_07]
		next_sda_oe    = i_sda_pull; // [RULE_07]
		next_scl_level = sync_q[SYNC_SCL]; // [RULE_07]
		next_sda_level = sync_q[SYNC_SDA]; // [RULE_07]
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin // [RULE_06]
			wr_active_d     <= 1'b0;
			hold_data       <= '0;
			hold_addr       <= '0;
			status_code_reg <= STATUS_IDLE;
			pointer_reg     <= POINTER_RESET[PTR_W-1:0];
			serial_byte_reg <= SERIAL_RESET;
			control_reg     <= CONTROL_RESET;
			for (int i = 0; i < INDIRECT_DEPTH; i++) begin
				indirect[i] <= INDIRECT_RESET[i];
			end
			si              <= 1'b0;
			bus_out         <= '0;
			bus_oe          <= 1'b0;
			irq_oe          <= 1'b0;
			scl_oe          <= 1'b0;
			sda_oe          <= 1'b0;
			scl_level       <= 1'b1;
			sda_level       <= 1'b1;
			pin_low         <= 1'b0;
		end else begin
			wr_active_d     <= next_wr_active_d;
			hold_data       <= next_hold_data;
			hold_addr       <= next_hold_addr;
			status_code_reg <= next_status_code_reg;
			pointer_reg     <= next_pointer_reg;
			serial_byte_reg <= next_serial_byte_reg;
			control_reg     <= next_control_reg;
			for (int i = 0; i < INDIRECT_DEPTH; i++) begin
				indirect[i] <= next_indirect[i];
			end
			si              <= next_si;
			bus_out         <= next_bus_out;
			bus_oe          <= next_bus_oe;
			irq_oe          <= next_irq_oe;
			scl_oe          <= next_scl_oe;
			sda_oe          <= next_sda_oe;
			scl_level       <= next_scl_level;
			sda_level       <= next_sda_level;
			pin_low         <= 1'b0;
		end
	end

	// Open-drain pins only ever drive a low level; the enable decides.
	assign o_irq_n_out       = pin_low; // [RULE_05]
	assign o_scl_out         = pin_low; // [RULE_07]
	assign o_sda_out         = pin_low; // [RULE_07]
	assign o_irq_n_oe        = irq_oe;
	assign o_scl_oe          = scl_oe;
	assign o_sda_oe          = sda_oe;
	assign o_host_bus_bits   = bus_out;
	assign o_host_bus_oe     = bus_oe;
	assign o_scl_level       = scl_level;
	assign o_sda_level       = sda_level;
	assign o_si              = si;
	assign o_control_reg     = {control_reg[7:SI_BIT+1], si, control_reg[SI_BIT-1:0]};
	assign o_serial_byte_reg = serial_byte_reg;
	assign o_pointer_reg     = pointer_reg;

endmodule

//--- bench/phpic_assertions.sv
`timescale 1ns/100ps
module phpic_checker
	import phpic_pkg::*;
(
	input wire logic              i_clock,
	input wire logic              i_rst_n,
	input wire logic              i_chip_sel_n,
	input wire logic              i_fetch_n,
	input wire logic              i_scl_pull,
	input wire logic              i_sda_pull,
	input wire logic [CODE_W-1:0] i_bus_state_code,
	input wire logic              i_bus_state_valid,
	input wire logic [DATA_W-1:0] o_host_bus_bits,
	input wire logic              o_host_bus_oe,
	input wire logic              o_irq_n_out,
	input wire logic              o_irq_n_oe,
	input wire logic              o_scl_out,
	input wire logic              o_scl_oe,
	input wire logic              o_sda_out,
	input wire logic              o_sda_oe,
	input wire logic              o_si
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	sel_release_a: assert property (i_chip_sel_n [*4] |-> !o_host_bus_oe)
		else $error("data bus driven while deselected");
	bus_quiet_a: assert property (!o_host_bus_oe |-> o_host_bus_bits == 8'h00)
		else $error("data seen while bus released");
	read_drive_a: assert property (!(i_chip_sel_n | i_fetch_n) [*5] |-> o_host_bus_oe)
		else $error("read not driven on bus");
	irq_low_a: assert property (o_irq_n_out == 1'b0)
		else $error("interrupt pin driven high");
	irq_flag_a: assert property (o_irq_n_oe == o_si)
		else $error("interrupt pin differs from flag");
	flag_set_a: assert property (i_bus_state_valid && i_bus_state_code != 6'h3e |=> o_si)
		else $error("state entry did not raise flag");
	pins_low_a: assert property (!o_scl_out && !o_sda_out)
		else $error("serial pin driven high");
	pull_follow_a: assert property ($past(i_rst_n) |-> o_scl_oe == $past(i_scl_pull))
		else $error("clock pin pull late");
	sda_follow_a: assert property ($past(i_rst_n) |-> o_sda_oe == $past(i_sda_pull))
		else $error("data pin pull late");
endmodule
bind phpic_host_port phpic_checker u_chk (.*);

//--- bench/phpic_host_model.sv
`timescale 1ns/100ps
module phpic_host_model
	import phpic_pkg::*;
(
	input  wire logic              i_clock,
	input  wire logic [DATA_W-1:0] i_bus,
	output logic                   o_sel_n,
	output logic                   o_store_n,
	output logic                   o_fetch_n,
	output logic                   o_lo,
	output logic                   o_hi,
	output logic      [DATA_W-1:0] o_data
);
	logic              drive = 1'b0;
	logic [DATA_W-1:0] last  = 8'h5a;
	initial begin
		{o_sel_n, o_store_n, o_fetch_n, o_lo, o_hi} = 5'h1c;
	end
	// A released bus shows the inverse of the last byte, never a stale copy.
	always_comb o_data = drive ? last : ~last;
	// Mode 0 raises store first, 1 raises select first, 2 keeps select high.
	task automatic wr(input logic [1:0] a, input logic [7:0] d, input int m);
		@(posedge i_clock);
		{o_hi, o_lo} <= a;
		last <= d;
		drive <= 1'b1;
		o_sel_n <= (m == 2);
		o_store_n <= 1'b0;
		repeat (4) @(posedge i_clock);
		if (m == 1) begin
			o_sel_n <= 1'b1;
		end else begin
			o_store_n <= 1'b1;
		end
		@(posedge i_clock);
		{o_sel_n, o_store_n} <= 2'h3;
		drive <= 1'b0;
		repeat (6) @(posedge i_clock);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] q);
		@(posedge i_clock);
		{o_hi, o_lo} <= a;
		{o_sel_n, o_fetch_n} <= 2'h0;
		repeat (5) @(posedge i_clock);
		q = i_bus;
		{o_sel_n, o_fetch_n} <= 2'h3;
		repeat (4) @(posedge i_clock);
	endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import phpic_pkg::*;
	logic i_clock = 0, i_rst_n = 0, i_bus_state_valid = 0, i_rx_byte_valid = 0;
	logic i_scl_pull = 0, i_sda_pull = 0;
	logic [5:0] i_bus_state_code = 6'h3e;
	logic [7:0] i_rx_byte = 8'h00, hdata, o_host_bus_bits, o_control_reg, o_serial_byte_reg;
	logic [2:0] o_pointer_reg;
	logic o_host_bus_oe, o_irq_n_out, o_irq_n_oe, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe;
	logic o_scl_level, o_sda_level, o_si;
	wire i_chip_sel_n, i_store_n, i_fetch_n, i_addr_bit_low, i_addr_bit_high;
	wire [7:0] i_host_bus_bits = o_host_bus_oe ? o_host_bus_bits : hdata;
	wire i_scl_in = ~o_scl_oe;
	wire i_sda_in = ~o_sda_oe;
	int fails = 0, total_checks = 0, seed = 32'h0768, ptr, ser, ctl, st, si, d;
	int ind[7];
	phpic_host_port u_phpic_host_port (.*);
	phpic_host_model u_host (.i_clock(i_clock), .i_bus(i_host_bus_bits),
		.o_sel_n(i_chip_sel_n), .o_store_n(i_store_n), .o_fetch_n(i_fetch_n),
		.o_lo(i_addr_bit_low), .o_hi(i_addr_bit_high), .o_data(hdata));
	always #25 i_clock = ~i_clock;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic reset_all();
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'b1;
		{ptr, ser, ctl, si, st} = {32'd0, 32'd0, 32'd0, 32'd0, 32'hf8};
		ind = '{8'h01, 8'he0, 8'h9d, 8'h86, 8'hff, 8'h00, 8'h00};
	endtask
	task automatic put(input logic [1:0] a, input logic [7:0] v, input int m);
		u_host.wr(a, v, m);
		if (m != 2) begin
			case (a)
				ADDR_STATUS: ptr = v % 8;
				ADDR_SERIAL: ser = v;
				ADDR_INDIRECT: if (ptr != 7) ind[ptr] = v;
				default: begin
					ctl = v & 8'hf7;
					if (!v[3]) si = 0;
				end
			endcase
		end
	endtask
	task automatic get(input logic [1:0] a);
		logic [7:0] q;
		int e;
		@(negedge i_clock);
		chk("pointer", 8'(ptr), {5'h0, o_pointer_reg});
		chk("serial", 8'(ser), o_serial_byte_reg);
		chk("control", 8'(ctl | (si << 3)), o_control_reg);
		u_host.rd(a, q);
		case (a)
			ADDR_STATUS: e = st;
			ADDR_SERIAL: e = ser;
			ADDR_INDIRECT: e = (ptr == 5 || ptr == 7) ? 0 : ind[ptr];
			default: e = ctl | (si << 3);
		endcase
		chk("read", e[7:0], q);
	endtask
	task automatic event_in(input logic [5:0] c);
		@(posedge i_clock);
		{i_bus_state_code, i_bus_state_valid} <= {c, 1'b1};
		@(posedge i_clock);
		i_bus_state_valid <= 1'b0;
		st = {24'h0, c, 2'b00};
		if (c != 6'h3e) si = 1;
		@(negedge i_clock);
		chk("si", si[7:0], o_si);
		chk("irq", si[7:0], o_irq_n_oe);
	endtask
	initial begin
		repeat (20000) @(posedge i_clock);
		fails++;
		tally_and_finish();
	end
	initial begin
		reset_all();
		get(ADDR_STATUS);
		for (int i = 0; i < 7; i++) begin
			if (i != 5) begin
				put(ADDR_STATUS, i, i % 2);
				get(ADDR_INDIRECT);
				put(ADDR_INDIRECT, $random(seed), (i + 1) % 2);
				get(ADDR_INDIRECT);
			end
		end
		for (int a = 1; a < 4; a += 2) begin
			get(a);
			put(a, $random(seed), a / 2);
			get(a);
			put(a, $random(seed), 2);
			get(a);
		end
		for (int p = 5; p < 8; p += 2) begin
			put(ADDR_STATUS, p, 0);
			put(ADDR_INDIRECT, 8'h3c, 0);
			get(ADDR_INDIRECT);
		end
		event_in(6'h3e);
		for (int k = 0; k < 4; k++) begin
			d = $random(seed);
			event_in(d[5:0] == 6'h3e ? 6'h02 : d[5:0]);
			event_in(6'h3e);
		end
		get(ADDR_STATUS);
		get(ADDR_CONTROL);
		put(ADDR_CONTROL, 8'h08, 0);
		get(ADDR_CONTROL);
		put(ADDR_CONTROL, 8'h00, 1);
		event_in(6'h3e);
		@(posedge i_clock);
		{i_rx_byte, i_rx_byte_valid} <= {8'(ser ^ 8'ha5), 1'b1};
		ser = ser ^ 8'ha5;
		@(posedge i_clock);
		i_rx_byte_valid <= 1'b0;
		get(ADDR_SERIAL);
		for (int k = 1; k < 3; k++) begin
			@(posedge i_clock);
			{i_scl_pull, i_sda_pull} <= k;
			repeat (6) @(posedge i_clock);
			@(negedge i_clock);
			chk("scl", !k[1], o_scl_level);
			chk("sda", !k[0], o_sda_level);
		end
		event_in(6'h05);
		reset_all();
		@(negedge i_clock);
		chk("si", 8'h00, o_si);
		get(ADDR_STATUS);
		get(ADDR_SERIAL);
		tally_and_finish();
	end
endmodule
